/* hw/csg_consts.svh */
// Purpose: constants of the status and segment list checker
// Assumes: byte addressed avalon slave, one word per register
// Notes: status codes are the adapter status byte values
`ifndef CSG_CONSTS_SVH
`define CSG_CONSTS_SVH
// register byte addresses
`define CSG_A_CTRL   6'h00
`define CSG_A_INFO   6'h04
`define CSG_A_LEN    6'h08
`define CSG_A_SPTR   6'h0C
`define CSG_A_SLEN   6'h10
`define CSG_A_SENSE  6'h14
`define CSG_A_STAT   6'h18
`define CSG_A_MOVED  6'h1C
// control bits
`define CSG_C_START  0
`define CSG_C_SCLR   1
`define CSG_C_HCLR   2
// adapter status codes
`define CSG_ST_OK    8'h00
`define CSG_ST_LNKF  8'h0B
`define CSG_ST_SELTO 8'h11
`define CSG_ST_OVRUN 8'h12
`define CSG_ST_BFREE 8'h13
`define CSG_ST_PHASE 8'h14
`define CSG_ST_MBOX  8'h15
`define CSG_ST_OPC   8'h16
`define CSG_ST_LUN   8'h17
`define CSG_ST_TDIR  8'h18
`define CSG_ST_DUP   8'h19
`define CSG_ST_SGL   8'h1A
// bus status bytes
`define CSG_BS_GOOD  8'h00
`define CSG_BS_CHK   8'h02
`define CSG_BS_BUSY  8'h08
// sense area
`define CSG_SN_DFLT  8'h0E
`define CSG_SN_NONE  8'h01
// control block layout
`define CSG_CDB_OFS  8'h12
`define CSG_SEG_MAX  5'h10
`define CSG_ENT_SZ   24'h00_0006
`define CSG_HELD     4
// busy retry period
`define CSG_RETRY_NS 1000
`define CSG_CLK_NS   10
`define CSG_RETRY_CYC (`CSG_RETRY_NS / `CSG_CLK_NS)
`endif

/* hw/csg_pkg.sv */
// Purpose: types of the status and segment list checker
// Assumes: constants live in csg_consts.svh
// Notes: none
package csg_pkg;
	typedef struct packed {
		logic       chain_first; // 26
		logic       chain_next;  // 25
		logic [2:0] init_id;     // 24:22
		logic [2:0] lun;         // 21:19
		logic [1:0] dir;         // 18:17
		logic       tgt_mode;    // 16
		logic [7:0] mbox_cmd;    // 15:8
		logic [7:0] opcode;      // 7:0
	} csg_info_s;
	typedef struct packed {
		logic [2:0] lun;
		logic [2:0] init_id;
		logic [1:0] dir;
	} csg_held_s;
	typedef enum logic [3:0] {
		CSG_IDLE  = 4'b0001,
		CSG_WALK  = 4'b0010,
		CSG_RUN   = 4'b0100,
		CSG_RETRY = 4'b1000
	} csg_state_e;
endpackage

/* hw/csg_checker.sv */
// Purpose: adapter status posting and scatter/gather list checking
// Assumes: link events arrive as one-cycle pulses on clk_sys
// Notes: first error posted ends the control block
// Functional notes
// - clean completion posts status 00.
// - linked complete with flag posts 0B and interrupts the host.
// - selection or reselection time-out posts 11.
// - more bytes than data length or segment sum posts 12.
// - unexpected bus free posts 13.
// - phase error posts 14, drives bus reset and reset interrupt.
// - outbound mailbox command other than 00..02 posts 15.
// - unknown operation code posts 16.
// - later linked block with different unit posts 17.
// - target block with invalid direction posts 18.
// - duplicate target block for unit, initiator, direction posts 19.
// - zero-length segment or bad boundary posts 1A.
// - initiator stores bus status; busy status retries periodically.
// - target mode records sent status 00, 02 or 08.
// - target mode writes received descriptor at byte 18 onward.
// - check condition requests sense with allocation length; 01 suppresses.
// - processor target check copies sense bytes to host block.
// - opcodes 00, 01 contiguous buffer; 02 locates a segment list.
// - entries are three-byte pointer and length, walked in order.
// - lists must hold one to sixteen segments.
// - start, count and next start XOR must be even.
// - allocation length 00 means fourteen sense bytes.
`include "csg_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module csg_checker
	import csg_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output var  logic [31:0] readdata,
	output var  logic        waitrequest,
	input  wire logic        ev_complete,
	input  wire logic        ev_linked_flag,
	input  wire logic        ev_sel_timeout,
	input  wire logic        ev_bus_free,
	input  wire logic        ev_phase_err,
	input  wire logic        ev_byte,
	input  wire logic        bus_status_vld,
	input  wire logic [7:0]  bus_status,
	input  wire logic        cdb_vld,
	output var  logic        adapter_status_wr,
	output var  logic [7:0]  adapter_status_byte,
	output var  logic        host_irq,
	output var  logic        bus_reset_drive,
	output var  logic        bus_reset_detected_interrupt,
	output var  logic        retry_req,
	output var  logic        sense_req,
	output var  logic [7:0]  sense_len,
	output var  logic        sense_copy,
	output var  logic        cdb_wr,
	output var  logic [7:0]  cdb_ofs
);
	csg_state_e  state;
	csg_info_s   info;
	logic [23:0] len;
	logic [23:0] sptr;
	logic [7:0]  alloc;
	logic [7:0]  tstat;
	logic [23:0] moved;
	logic [23:0] limit;
	logic [23:0] seg_ptr [0:15];
	logic [23:0] seg_len [0:15];
	logic [4:0]  seg_cnt;
	logic        seg_ovf;
	logic [3:0]  idx;
	logic [2:0]  chain_lun;
	logic [15:0] rcnt;
	csg_held_s   held [0:`CSG_HELD-1];
	logic [`CSG_HELD-1:0] held_v;
	logic [`CSG_HELD-1:0] hit;

	// bus strobes: a request is taken on the edge with waitrequest low
	wire acc = (read | write) & ~waitrequest;
	wire wr_ctrl = write & acc & (address == `CSG_A_CTRL);
	wire start = wr_ctrl & writedata[`CSG_C_START] & (state == CSG_IDLE);
	wire sclr = wr_ctrl & writedata[`CSG_C_SCLR] & (state == CSG_IDLE);
	wire hclr = wr_ctrl & writedata[`CSG_C_HCLR];
	wire push = write & acc & (address == `CSG_A_SLEN) & (state == CSG_IDLE);
	wire idle_wr = write & acc & (state == CSG_IDLE);

	// reads the register selected by a byte address
	function automatic logic [31:0] rd_mux(input logic [5:0] a);
		case (a)
			`CSG_A_CTRL:  rd_mux = {28'h000_0000, state};
			`CSG_A_INFO:  rd_mux = {5'h00, info};
			`CSG_A_LEN:   rd_mux = {8'h00, len};
			`CSG_A_SPTR:  rd_mux = {8'h00, sptr};
			`CSG_A_SENSE: rd_mux = {24'h00_0000, alloc};
			`CSG_A_STAT:  rd_mux = {10'h000, seg_ovf, seg_cnt, tstat, adapter_status_byte};
			`CSG_A_MOVED: rd_mux = {8'h00, moved};
			default:      rd_mux = 32'h0000_0000;
		endcase
	endfunction

	// front checks at start, highest priority first
	wire n_tdir = info.tgt_mode & (info.dir[1] == info.dir[0]);
	wire [7:0] pre_code =
		(info.mbox_cmd > 8'h02) ? `CSG_ST_MBOX :
		(info.opcode > 8'h02) ? `CSG_ST_OPC :
		(info.chain_next & (info.lun != chain_lun)) ? `CSG_ST_LUN :
		n_tdir ? `CSG_ST_TDIR :
		(info.tgt_mode & |hit) ? `CSG_ST_DUP :
		(info.opcode == 8'h02 & (seg_cnt == 5'h00 | seg_ovf)) ? `CSG_ST_SGL :
		(info.opcode == 8'h02 & (len != {16'h0000, seg_cnt, 3'h0} - {18'h0_0000, seg_cnt, 1'b0}))
			? `CSG_ST_SGL : `CSG_ST_OK;

	// duplicate match against held target blocks
	genvar g;
	generate
		for (g = 0; g < `CSG_HELD; g = g + 1) begin : g_hit
			assign hit[g] = held_v[g] & (held[g] == {info.lun, info.init_id, info.dir});
		end
	endgenerate
	wire hold_new = start & info.tgt_mode & (pre_code == `CSG_ST_OK);

	// per-entry checks of the walk
	wire last = ({1'b0, idx} == seg_cnt - 5'h01);
	wire [3:0] nidx = idx + 4'h1;
	wire zlen = (seg_len[idx] == 24'h00_0000);
	wire bnd = ~last & (seg_ptr[idx][0] ^ seg_len[idx][0] ^ seg_ptr[nidx][0]);
	wire [23:0] nlim = limit + seg_len[idx];
	wire over = ev_byte & (moved == limit);
	wire [7:0] sn_len = (alloc == 8'h00) ? `CSG_SN_DFLT : alloc;
	wire chk = bus_status_vld & (bus_status == `CSG_BS_CHK);

	// run-time event code
	wire [7:0] run_code =
		ev_phase_err ? `CSG_ST_PHASE :
		ev_sel_timeout ? `CSG_ST_SELTO :
		ev_bus_free ? `CSG_ST_BFREE :
		over ? `CSG_ST_OVRUN :
		ev_linked_flag ? `CSG_ST_LNKF :
		`CSG_ST_OK;
	wire run_end = ev_phase_err | ev_sel_timeout | ev_bus_free | over |
		ev_linked_flag | ev_complete;

	// avalon handshake, one wait state per access
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			waitrequest <= 1'b1;
			readdata <= 32'h0000_0000;
		end else begin
			waitrequest <= ~((read | write) & waitrequest);
			if (read & waitrequest)
				readdata <= rd_mux(address);
		end
	end

	// software registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			info <= '0;
			len <= 24'h00_0000;
			sptr <= 24'h00_0000;
			alloc <= 8'h00;
		end else if (idle_wr) begin
			if (address == `CSG_A_INFO)
				info <= writedata[26:0];
			if (address == `CSG_A_LEN)
				len <= writedata[23:0];
			if (address == `CSG_A_SPTR)
				sptr <= writedata[23:0];
			if (address == `CSG_A_SENSE)
				alloc <= writedata[7:0];
		end
	end

	// segment list store, entries kept in list order
	always_ff @(posedge clk_sys) begin
		if (push & ~seg_cnt[4])
			seg_ptr[seg_cnt[3:0]] <= sptr;
		if (push & ~seg_cnt[4])
			seg_len[seg_cnt[3:0]] <= writedata[23:0];
	end

	// segment count and overflow
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			seg_cnt <= 5'h00;
			seg_ovf <= 1'b0;
		end else if (sclr) begin
			seg_cnt <= 5'h00;
			seg_ovf <= 1'b0;
		end else if (push) begin
			if (seg_cnt == `CSG_SEG_MAX)
				seg_ovf <= 1'b1;
			else
				seg_cnt <= seg_cnt + 5'h01;
		end
	end

	// held target blocks, newest in slot zero
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			held_v <= '0;
		end else if (hclr) begin
			held_v <= {{(`CSG_HELD-1){1'b0}}, hold_new}; // new block beats the clear
		end else if (hold_new) begin
			held_v <= {held_v[`CSG_HELD-2:0], 1'b1};
		end
	end

	// held entry contents
	always_ff @(posedge clk_sys) begin
		if (hold_new) begin
			held[0] <= {info.lun, info.init_id, info.dir};
			for (int k = 1; k < `CSG_HELD; k++)
				held[k] <= held[k-1];
		end
	end

	// main sequence: check, walk list, run, retry on busy
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= CSG_IDLE;
			idx <= 4'h0;
			limit <= 24'h00_0000;
			moved <= 24'h00_0000;
			rcnt <= 16'h0000;
			chain_lun <= 3'h0;
			adapter_status_byte <= `CSG_ST_OK;
			adapter_status_wr <= 1'b0;
			host_irq <= 1'b0;
		end else begin
			adapter_status_wr <= 1'b0;
			host_irq <= 1'b0;
			case (state)
				CSG_IDLE: begin
					if (start) begin
						idx <= 4'h0;
						moved <= 24'h00_0000;
						if (info.chain_first)
							chain_lun <= info.lun;
						if (pre_code != `CSG_ST_OK) begin
							adapter_status_byte <= pre_code;
							adapter_status_wr <= 1'b1;
						end else if (info.opcode == 8'h02) begin
							limit <= 24'h00_0000;
							state <= CSG_WALK;
						end else begin
							limit <= len;
							state <= CSG_RUN;
						end
					end
				end
				CSG_WALK: begin
					limit <= nlim;
					idx <= nidx;
					if (zlen | bnd) begin
						adapter_status_byte <= `CSG_ST_SGL;
						adapter_status_wr <= 1'b1;
						state <= CSG_IDLE;
					end else if (last) begin
						state <= CSG_RUN;
					end
				end
				CSG_RUN: begin
					if (ev_byte & ~over)
						moved <= moved + 24'h00_0001;
					if (bus_status_vld & ~info.tgt_mode & (bus_status == `CSG_BS_BUSY)) begin
						rcnt <= 16'(`CSG_RETRY_CYC);
						state <= CSG_RETRY;
					end else if (run_end) begin
						adapter_status_byte <= run_code;
						adapter_status_wr <= 1'b1;
						host_irq <= ev_linked_flag & ~(ev_phase_err | ev_sel_timeout |
							ev_bus_free | over);
						state <= CSG_IDLE;
					end
				end
				CSG_RETRY: begin
					rcnt <= rcnt - 16'h0001;
					if (rcnt == 16'h0001) begin
						moved <= 24'h00_0000;
						state <= CSG_RUN;
					end
				end
				default: state <= CSG_IDLE;
			endcase
		end
	end

	// bus status, sense and reset side effects
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tstat <= `CSG_BS_GOOD;
			sense_req <= 1'b0;
			sense_len <= 8'h00;
			sense_copy <= 1'b0;
			retry_req <= 1'b0;
			bus_reset_drive <= 1'b0;
			bus_reset_detected_interrupt <= 1'b0;
		end else begin
			if (bus_status_vld)
				tstat <= bus_status;
			sense_req <= chk & ~info.tgt_mode & (alloc != `CSG_SN_NONE) &
				(state == CSG_RUN);
			sense_copy <= chk & info.tgt_mode & (state == CSG_RUN);
			if (chk)
				sense_len <= sn_len;
			retry_req <= (state == CSG_RETRY) & (rcnt == 16'h0001);
			bus_reset_drive <= (state == CSG_RUN) & ev_phase_err;
			bus_reset_detected_interrupt <= (state == CSG_RUN) & ev_phase_err;
		end
	end

	// received descriptor bytes go to byte 18 onward in target mode
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cdb_wr <= 1'b0;
			cdb_ofs <= `CSG_CDB_OFS;
		end else begin
			cdb_wr <= cdb_vld & info.tgt_mode & (state == CSG_RUN);
			if (start)
				cdb_ofs <= `CSG_CDB_OFS;
			else if (cdb_wr)
				cdb_ofs <= cdb_ofs + 8'h01;
		end
	end

	// checks
	property p_ok;
		@(posedge clk_sys) disable iff (!rst_b)
		(state == CSG_RUN && ev_complete && !ev_linked_flag && !ev_phase_err &&
		 !ev_sel_timeout && !ev_bus_free && !over && !bus_status_vld)
		|=> adapter_status_wr && adapter_status_byte == 8'h00;
	endproperty
	a_ok: assert property (p_ok) else $error("clean completion not 00");
	property p_lnk;
		@(posedge clk_sys) disable iff (!rst_b)
		(state == CSG_RUN && ev_linked_flag && !ev_phase_err && !ev_sel_timeout && !ev_bus_free &&
		 !over && !bus_status_vld) |=> host_irq && adapter_status_byte == 8'h0B;
	endproperty
	a_lnk: assert property (p_lnk) else $error("linked flag missed");
	property p_phase;
		@(posedge clk_sys) disable iff (!rst_b)
		(state == CSG_RUN && ev_phase_err && !bus_status_vld)
		|=> bus_reset_drive && bus_reset_detected_interrupt && adapter_status_byte == 8'h14;
	endproperty
	a_phase: assert property (p_phase) else $error("phase error handling");
	property p_mbox;
		@(posedge clk_sys) disable iff (!rst_b)
		(start && info.mbox_cmd > 8'h02) |=> adapter_status_byte == 8'h15 && state == CSG_IDLE;
	endproperty
	a_mbox: assert property (p_mbox) else $error("bad mailbox not 15");
	property p_opc;
		@(posedge clk_sys) disable iff (!rst_b)
		(start && info.mbox_cmd <= 8'h02 && info.opcode > 8'h02) |=> adapter_status_byte == 8'h16;
	endproperty
	a_opc: assert property (p_opc) else $error("bad opcode not 16");
	property p_tdir;
		@(posedge clk_sys) disable iff (!rst_b)
		(start && info.mbox_cmd <= 8'h02 && info.opcode <= 8'h02 && !info.chain_next &&
		 info.tgt_mode && info.dir[1] == info.dir[0]) |=> adapter_status_byte == 8'h18;
	endproperty
	a_tdir: assert property (p_tdir) else $error("target direction not 18");
	property p_sgl;
		@(posedge clk_sys) disable iff (!rst_b)
		(state == CSG_WALK && zlen) |=> adapter_status_byte == 8'h1A ##1 state == CSG_IDLE;
	endproperty
	a_sgl: assert property (p_sgl) else $error("zero segment not 1A");
	property p_cnt;
		@(posedge clk_sys) disable iff (!rst_b)
		(start && info.opcode == 8'h02 && info.mbox_cmd <= 8'h02 && seg_cnt == 5'h00 &&
		 !n_tdir && !info.chain_next && !info.tgt_mode) |=> adapter_status_byte == 8'h1A;
	endproperty
	a_cnt: assert property (p_cnt) else $error("empty list accepted");
	property p_sense;
		@(posedge clk_sys) disable iff (!rst_b)
		(chk && alloc == 8'h00) |=> sense_len == 8'h0E;
	endproperty
	a_sense: assert property (p_sense) else $error("default sense length wrong");
	property p_nosense;
		@(posedge clk_sys) disable iff (!rst_b)
		(alloc == 8'h01 && $stable(alloc)) |=> !sense_req;
	endproperty
	a_nosense: assert property (p_nosense) else $error("sense issued with 01");
	property p_retry;
		@(posedge clk_sys) disable iff (!rst_b)
		(state == CSG_RUN && bus_status_vld && !info.tgt_mode && bus_status == 8'h08)
		|=> state == CSG_RETRY ##[1:120] retry_req;
	endproperty
	a_retry: assert property (p_retry) else $error("busy retry missing");
endmodule
`default_nettype wire

/* tb/csg_link_model.sv */
// Purpose: scsi bus side stand-in that drives the link events
// Assumes: every event is a one-cycle pulse on clk_sys
// Notes: the status byte is inverted once it is no longer valid
`timescale 1ns/10ps
`default_nettype none
module csg_link_model (
	input  wire logic       clk_sys,
	output wire logic       ev_complete,
	output wire logic       ev_linked_flag,
	output wire logic       ev_sel_timeout,
	output wire logic       ev_bus_free,
	output wire logic       ev_phase_err,
	output wire logic       ev_byte,
	output wire logic       bus_status_vld,
	output var  logic [7:0] bus_status,
	output wire logic       cdb_vld
);
	logic [7:0] ev = 8'h00;
	// one event line per bit, lowest bit is completion
	assign {cdb_vld, bus_status_vld, ev_byte, ev_phase_err, ev_bus_free, ev_sel_timeout,
		ev_linked_flag, ev_complete} = ev;
	initial bus_status = 8'h5A;
	// idle gap for a slow target, one pulse, then one quiet cycle
	task automatic send(input int kind, input logic [7:0] val, input int gap);
		repeat (gap) @(posedge clk_sys);
		if (kind == 6) bus_status <= val;
		ev <= 8'(1 << kind);
		@(posedge clk_sys);
		ev <= 8'h00;
		if (kind == 6) bus_status <= ~val; // stale byte is never held
		@(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

/* tb/csg_checker_bench.sv */
// Purpose: self-checking bench for the status and segment list checker
// Assumes: register accesses wait for waitrequest low, no fixed latency
// Notes: expected codes come from a queue based model of the checks
`include "csg_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module csg_checker_bench;
	logic        clk_sys = 1'b0;
	logic        rst_b, read, write, waitrequest, adapter_status_wr, host_irq;
	logic        bus_reset_drive, bus_reset_detected_interrupt, retry_req, sense_req;
	logic        sense_copy, cdb_wr, ev_complete, ev_linked_flag, ev_sel_timeout;
	logic        ev_bus_free, ev_phase_err, ev_byte, bus_status_vld, cdb_vld;
	logic [5:0]  address;
	logic [31:0] writedata, readdata;
	logic [7:0]  adapter_status_byte, sense_len, cdb_ofs, bus_status, last_len;
	logic [7:0]  posted[$], ofs_q[$];
	int          held[$], sptr[$], slen[$];
	int          fails = 0, num_checks = 0, seed = 32'h0000_A3FC, chain_lun = 0;
	int          ssum, llen, n_sense, n_copy, n_retry, n_irq = 0, n_rst = 0;

	csg_checker DUT (.clk_sys(clk_sys), .rst_b(rst_b), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .ev_complete(ev_complete),
		.ev_linked_flag(ev_linked_flag), .ev_sel_timeout(ev_sel_timeout),
		.ev_bus_free(ev_bus_free), .ev_phase_err(ev_phase_err), .ev_byte(ev_byte),
		.bus_status_vld(bus_status_vld), .bus_status(bus_status), .cdb_vld(cdb_vld),
		.adapter_status_wr(adapter_status_wr), .adapter_status_byte(adapter_status_byte),
		.host_irq(host_irq), .bus_reset_drive(bus_reset_drive),
		.bus_reset_detected_interrupt(bus_reset_detected_interrupt),
		.retry_req(retry_req), .sense_req(sense_req), .sense_len(sense_len),
		.sense_copy(sense_copy), .cdb_wr(cdb_wr), .cdb_ofs(cdb_ofs));
	csg_link_model LINK (.clk_sys(clk_sys), .ev_complete(ev_complete),
		.ev_linked_flag(ev_linked_flag), .ev_sel_timeout(ev_sel_timeout),
		.ev_bus_free(ev_bus_free), .ev_phase_err(ev_phase_err), .ev_byte(ev_byte),
		.bus_status_vld(bus_status_vld), .bus_status(bus_status), .cdb_vld(cdb_vld));

	// free running system clock
	always #5 clk_sys = ~clk_sys;

	// collect pulses and postings from the design
	always @(posedge clk_sys) begin
		if (adapter_status_wr === 1'b1) posted.push_back(adapter_status_byte);
		if (cdb_wr === 1'b1) ofs_q.push_back(cdb_ofs);
		if (sense_req === 1'b1) begin
			n_sense++;
			last_len = sense_len;
		end
		n_copy += int'(sense_copy === 1'b1);
		n_retry += int'(retry_req === 1'b1);
		n_irq += int'(host_irq === 1'b1);
		n_rst += int'(bus_reset_drive === 1'b1) + int'(bus_reset_detected_interrupt === 1'b1);
	end

	task automatic tally_and_finish;
		if (fails == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic give_up;
		fails++;
		tally_and_finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_sys);
			if (waitrequest === 1'b0) break;
		end
		q = readdata;
		if (i == 50) give_up;
		write <= 1'b0;
		read <= 1'b0;
		writedata <= $random(seed);
		@(posedge clk_sys);
	endtask

	// model of the start checks, in priority order
	function automatic int front(logic [31:0] info, int len);
		int n;
		n = sptr.size();
		if (info[15:8] > 8'h02) return 8'h15;
		if (info[7:0] > 8'h02) return 8'h16;
		if (info[25] && info[21:19] != chain_lun) return 8'h17;
		if (info[16] && info[18:17] inside {2'b00, 2'b11}) return 8'h18;
		if (info[16] && int'(info[24:17]) inside {held}) return 8'h19;
		if (info[7:0] != 8'h02) return -1;
		if (n == 0 || n > 16 || len != 6 * n) return 8'h1A;
		for (int i = 0; i < n; i++)
			if (slen[i] == 0 || (i < n - 1 && ((sptr[i] ^ slen[i] ^ sptr[i+1]) & 1)))
				return 8'h1A;
		return -1;
	endfunction

	// start a block, play the bus side, compare the posted status
	task automatic run(input logic [31:0] info, input int len, input int kind, input int val);
		int f, e, c, lim;
		logic [31:0] q;
		logic [7:0] b;
		int codes[5] = '{8'h00, 8'h0B, 8'h11, 8'h13, 8'h14};
		n_retry = 0;
		bus(1'b1, `CSG_A_INFO, info, q);
		bus(1'b1, `CSG_A_LEN, len, q);
		bus(1'b1, `CSG_A_CTRL, 32'h0000_0001, q);
		f = front(info, len);
		lim = (info[7:0] == 8'h02) ? ssum : len;
		if (info[26]) chain_lun = info[21:19];
		if (f < 0 && info[16]) held.push_back(info[24:17]);
		e = f;
		if (f < 0) begin
			q = 0;
			for (c = 0; c < 40 && q !== 32'h0000_0004; c++) bus(1'b0, `CSG_A_CTRL, 0, q);
			cmp(q, 32'h0000_0004);
			e = (kind < 5) ? codes[kind] : ((kind == 5 && val > lim) ? 8'h12 : 8'h00);
			repeat ((kind < 5 || kind == 6) ? 1 : val) LINK.send(kind, val, {$random(seed)} % 3);
			if (kind == 6 && val == 8 && !info[16]) begin
				for (c = 0; c < 300 && n_retry == 0; c++) @(posedge clk_sys);
				cmp(c >= `CSG_RETRY_CYC && c <= `CSG_RETRY_CYC + 1, 1);
			end
			if (kind > 4) LINK.send(0, 0, {$random(seed)} % 3);
		end
		for (c = 0; c < 600 && posted.size() == 0; c++) @(posedge clk_sys);
		if (posted.size() == 0) give_up;
		b = posted.pop_front();
		cmp(b, e);
		bus(1'b0, `CSG_A_STAT, 0, q);
		cmp(q[7:0], e);
		if (kind == 6) cmp(q[15:8], val);
	endtask

	// load a random segment list, optionally spoiled in one way
	task automatic build(input int n, input int bad);
		logic [31:0] q;
		bus(1'b1, `CSG_A_CTRL, 32'h0000_0002, q);
		sptr.delete();
		slen.delete();
		ssum = 0;
		for (int i = 0; i < n; i++) begin
			sptr.push_back({$random(seed)} & 32'h00FF_FFFE);
			slen.push_back(2 + 2 * ({$random(seed)} % 8));
		end
		if (bad == 1) slen[n-1] = 0;
		if (bad == 2) slen[0] = slen[0] + 1;
		for (int i = 0; i < n; i++) begin
			bus(1'b1, `CSG_A_SPTR, sptr[i], q);
			bus(1'b1, `CSG_A_SLEN, slen[i], q);
			ssum += slen[i];
		end
		bus(1'b0, `CSG_A_STAT, 0, q);
		cmp(q[21:16], {n > 16, 5'(n > 16 ? 16 : n)});
		llen = 6 * n + int'(bad == 3);
	endtask

	// main sequence
	initial begin
		logic [31:0] q;
		int nt[5] = '{0, 17, 4, 4, 4};
		int bt[5] = '{0, 0, 1, 2, 3};
		int tv[3] = '{8'h00, 8'h02, 8'h08};
		int al[3] = '{8'h00, 8'h01, 8'h20};
		rst_b = 1'b0;
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0000_0000;
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		bus(1'b0, 6'h20, 0, q);
		cmp(q, 32'h0000_0000);
		bus(1'b0, `CSG_A_CTRL, 0, q);
		cmp(q, 32'h0000_0001);
		for (int i = 0; i < 5; i++) run(0, 4, i, 0);
		cmp(n_irq, 1);
		cmp(n_rst, 2);
		run(0, 3, 5, 3);
		run(0, 3, 5, 4);
		for (int i = 0; i < 4; i++) run(i << 8, 0, 0, 0);
		run(32'h0000_0003, 0, 0, 0);
		run(32'h0410_0000, 0, 0, 0);
		run(32'h0210_0000, 0, 0, 0);
		run(32'h0228_0000, 0, 0, 0);
		bus(1'b1, `CSG_A_CTRL, 32'h0000_0004, q);
		held.delete();
		for (int d = 0; d < 4; d++) run(32'h0001_0000 | (d << 17), 0, 0, 0);
		run(32'h0003_0000, 0, 0, 0);
		bus(1'b1, `CSG_A_CTRL, 32'h0000_0004, q);
		held.delete();
		n_copy = 0;
		for (int i = 0; i < 3; i++) run(32'h0003_0000 | (i << 22), 0, 6, tv[i]);
		cmp(n_copy, 1);
		bus(1'b1, `CSG_A_CTRL, 32'h0000_0004, q);
		held.delete();
		run(32'h0003_0000, 0, 7, 3);
		cmp(ofs_q.size(), 3);
		for (int i = 0; i < 3; i++) cmp(ofs_q[i], 8'h12 + i);
		for (int i = 0; i < 3; i++) begin
			n_sense = 0;
			bus(1'b1, `CSG_A_SENSE, al[i], q);
			run(0, 0, 6, 2);
			cmp(n_sense, al[i] != 1);
			if (al[i] != 1) cmp(last_len, al[i] == 0 ? 14 : al[i]);
		end
		run(0, 0, 6, 8);
		for (int i = 0; i < 5; i++) begin
			build(nt[i], bt[i]);
			run(32'h0000_0002, llen, 0, 0);
		end
		build(16, 0);
		run(32'h0000_0002, llen, 5, ssum + 1);
		build(1, 0);
		run(32'h0000_0002, llen, 5, ssum);
		tally_and_finish;
	end
endmodule
`default_nettype wire
